/* File: rtl/selprep_regs.svh */
// offsets, field positions, reset values and timing counts of the selection sequencer
// assumes the includer compiles it once per unit; guarded against double inclusion
`ifndef SELPREP_REGS_SVH
`define SELPREP_REGS_SVH

// ------------------------------------------------------------
// register offsets (word index on the plain port)
// ------------------------------------------------------------
`define OFF_HOST_BUS_ADDRESS  4'h0
`define OFF_TABLE_BASE_OFFSET 4'h1
`define OFF_CONTROL           4'h2
`define OFF_STATUS            4'h3
`define OFF_TRANSFER_DATA     4'h4
`define OFF_UNIT_ADDR         4'h5
`define OFF_UNIT_REGS         4'h6

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define CTL_GO_BIT            0
`define CTL_DONE_BIT          1
`define CTL_DONE_WE_BIT       2
`define CTL_FCODE_LSB         4
`define CTL_FCODE_MSB         5

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RST_WORD16            16'h0000
`define RST_BYTE              8'h00
`define TIME_CYCLE_NS         200
`define CLK_PERIOD_NS         40
`define TIME_STATE_CYCLES     ((`TIME_CYCLE_NS / 2) / `CLK_PERIOD_NS)

`endif

/* File: rtl/selprep_pkg.sv */
// types shared by the selection sequencer and its bench
// assumes selprep_regs.svh for numeric constants
package selprep_pkg;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR_RESP, PH_STAT_PREP, PH_STAT_PRES,
        PH_MARK, PH_INPUT, PH_OUTPUT, PH_DONE
    } phase_e;

    // channel tags arriving at the device
    typedef struct packed {
        logic       addr_out_tag;
        logic       cmd_out_tag;
        logic       select_out;
        logic       operational_out;
        logic       initial_selection;
        logic       channel_reset_seen;
        logic       parity_good;
        logic [7:0] outbound_bus;
    } chan_in_s;

    // memory transfer request to host bus logic
    typedef struct packed {
        logic        mem_request_active;
        logic [15:0] host_bus_address;
    } mem_req_s;

    // complete sequencer state
    typedef struct packed {
        phase_e      phase;
        logic        time_state_two;
        logic [1:0]  tcnt;
        logic        sync;
        logic        skip_fetch_flag;
        logic        done_flag;
        logic        go_bit;
        logic        request_in;
        logic        addr_in_tag;
        logic        mem_request_active;
        logic        reset_pulse;
        logic        seq_started;
        logic        cmd_taken;
        logic [1:0]  function_code;
        logic [1:0]  held_function;
        logic [15:0] host_bus_address;
        logic [15:0] table_base_offset;
        logic [15:0] transfer_data_reg;
        logic [7:0]  unit_addr_latch;
        logic [7:0]  unit_status_reg;
        logic [7:0]  unit_command_reg;
        logic [7:0]  inbound_bus;
        logic [15:0] rdata;
    } state_s;

endpackage

/* File: rtl/selprep.sv */
// selection sequencer: address response and status preparation phases
// assumes channel tags come from pins; host bus logic answers memory reads
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "selprep_regs.svh"

module selprep (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // register port
    input  wire logic [3:0]            addr_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [15:0]                rdata_o,
    // channel pins
    input  wire selprep_pkg::chan_in_s chan_i,
    output logic                       addr_in_tag_o,
    output logic                       request_in_o,
    output logic [7:0]                 inbound_bus_o,
    // host memory
    output selprep_pkg::mem_req_s      mem_o,
    input  wire logic                  mem_done_i,
    input  wire logic [15:0]           mem_data_i,
    // sequencer view
    output selprep_pkg::phase_e        phase_o,
    output logic                       sync_o,
    output logic                       skip_fetch_o
);
    import selprep_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    chan_in_s chan_meta;
    chan_in_s chan_s;
    logic     done_meta;
    logic     done_s;
    logic     [15:0] mdata_meta;
    logic     [15:0] mdata_s;

    always_ff @(posedge clk_i) begin
        chan_meta  <= chan_i;
        chan_s     <= chan_meta;
        done_meta  <= mem_done_i;
        done_s     <= done_meta;
        mdata_meta <= mem_data_i;
        mdata_s    <= mdata_meta;
    end

    state_s st;
    state_s next_st;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic tick;
        logic ts1;
        logic ts2;
        logic wr_ctl;
        tick    = 1'b0;
        ts1     = 1'b0;
        ts2     = 1'b0;
        wr_ctl  = 1'b0;
        next_st = st;
        next_st.reset_pulse = 1'b0;

        // time states alternate every TIME_STATE_CYCLES clocks: the half time cycle rounded down to 2 clocks (80 ns, not 100 ns)
        tick = (st.tcnt == 2'((`TIME_STATE_CYCLES) - 1));
        next_st.tcnt = tick ? 2'h0 : 2'(st.tcnt + 2'h1);
        if (tick) begin
            next_st.time_state_two = ~st.time_state_two;
        end
        ts1 = tick && !st.time_state_two;
        ts2 = tick && st.time_state_two;

        if (st.mem_request_active && done_s) begin
            next_st.mem_request_active = 1'b0;
            next_st.transfer_data_reg  = mdata_s;
        end

        // register writes
        wr_ctl = wr_i && (addr_i == `OFF_CONTROL);
        if (wr_i && addr_i == `OFF_HOST_BUS_ADDRESS) begin
            next_st.host_bus_address = wdata_i;
        end
        if (wr_i && addr_i == `OFF_TABLE_BASE_OFFSET) begin
            next_st.table_base_offset = wdata_i;
        end
        if (wr_ctl) begin
            next_st.go_bit = wdata_i[`CTL_GO_BIT];
            if (!st.seq_started) begin
                next_st.function_code = wdata_i[`CTL_FCODE_MSB:`CTL_FCODE_LSB];
            end
            // done writable in phases 0 and 7
            if (wdata_i[`CTL_DONE_WE_BIT] && (st.phase == PH_IDLE || st.phase == PH_DONE)) begin
                next_st.done_flag = wdata_i[`CTL_DONE_BIT];
            end
        end

        case (st.phase)
            PH_IDLE: begin
                // go with code: request or reset
                if (ts1 && st.go_bit && st.function_code != 2'h0) begin
                    next_st.request_in = 1'b1;
                end else if (ts1 && st.go_bit) begin
                    next_st.reset_pulse = 1'b1;
                    next_st.go_bit      = 1'b0;
                    next_st.request_in  = 1'b0;
                    next_st.sync        = 1'b0;
                    next_st.seq_started = 1'b0;
                end
                // address response only on initial selection
                if (ts2 && chan_s.initial_selection && chan_s.addr_out_tag && chan_s.select_out) begin
                    next_st.unit_addr_latch = chan_s.outbound_bus;
                    next_st.held_function   = st.function_code;
                    next_st.seq_started     = 1'b1;
                    next_st.cmd_taken       = 1'b0;
                    next_st.request_in      = 1'b0;
                    next_st.skip_fetch_flag = 1'b0;
                    next_st.sync            = 1'b0;
                    next_st.phase           = PH_ADDR_RESP;
                end
            end
            PH_ADDR_RESP: begin
                if (ts1 && !st.sync) begin
                    next_st.host_bus_address   = {st.table_base_offset[15:10], 1'b0,
                                                  st.unit_addr_latch, 1'b0};
                    next_st.mem_request_active = 1'b1;
                    next_st.sync               = 1'b1;
                end
                if (ts2 && st.sync && !st.mem_request_active) begin
                    next_st.unit_status_reg = st.transfer_data_reg[7:0];
                    next_st.inbound_bus     = st.unit_addr_latch;
                    if (st.transfer_data_reg[7:0] != 8'h00 || st.transfer_data_reg[15:8] == 8'h00) begin
                        next_st.skip_fetch_flag = 1'b1;
                    end
                    if (st.transfer_data_reg[7:0] == 8'h00) begin
                        next_st.unit_status_reg = `RST_BYTE;
                    end
                    next_st.sync = 1'b0;
                    next_st.phase = chan_s.channel_reset_seen ? PH_MARK : PH_STAT_PREP;
                end
            end
            PH_STAT_PREP: begin
                if (ts1 && !st.sync) begin
                    if (!chan_s.addr_out_tag && !chan_s.cmd_out_tag && !st.addr_in_tag && !st.cmd_taken) begin
                        next_st.addr_in_tag = 1'b1;
                    end
                    if (chan_s.cmd_out_tag && st.addr_in_tag) begin
                        next_st.unit_command_reg = chan_s.outbound_bus;
                        next_st.cmd_taken        = 1'b1;
                        next_st.addr_in_tag      = 1'b0;
                        next_st.skip_fetch_flag  = !chan_s.parity_good;
                        if (chan_s.parity_good && !st.skip_fetch_flag && chan_s.operational_out) begin
                            next_st.host_bus_address   = {st.transfer_data_reg[15:8], chan_s.outbound_bus};
                            next_st.mem_request_active = 1'b1;
                            next_st.sync               = 1'b1;
                            next_st.skip_fetch_flag    = 1'b0;
                        end else begin
                            next_st.skip_fetch_flag = 1'b1;
                        end
                    end
                end
                if (!chan_s.select_out || chan_s.channel_reset_seen) begin
                    next_st.addr_in_tag = 1'b0;
                    next_st.sync        = 1'b0;
                    next_st.phase       = PH_MARK;
                // second time state needs address-out low
                end else if (ts2 && !chan_s.addr_out_tag) begin
                    if (st.sync && !st.mem_request_active) begin
                        next_st.unit_status_reg = st.unit_command_reg[0] ? st.transfer_data_reg[15:8]
                                                                         : st.transfer_data_reg[7:0];
                        next_st.sync  = 1'b0;
                        next_st.phase = PH_STAT_PRES;
                    // next phase from held code
                    // bypass only once the command byte was taken, else address-in is never shown
                    end else if (!st.sync && !st.addr_in_tag && st.skip_fetch_flag && st.cmd_taken) begin
                        case (st.held_function)
                            2'h1:    next_st.phase = PH_INPUT;
                            2'h2:    next_st.phase = PH_OUTPUT;
                            default: next_st.phase = PH_STAT_PRES;
                        endcase
                    end
                end
            end
            PH_STAT_PRES: begin
                // odd command to input, even to output
                if (ts2) begin
                    next_st.phase = st.unit_command_reg[0] ? PH_INPUT : PH_OUTPUT;
                end
            end
            PH_INPUT, PH_OUTPUT: begin
                if (ts2 && !st.mem_request_active) begin
                    next_st.phase = PH_MARK;
                end
            end
            PH_MARK: begin
                // two memory writes log the event
                if (ts1 && !st.sync && !st.mem_request_active) begin
                    next_st.mem_request_active = 1'b1;
                    next_st.sync               = 1'b1;
                end
                if (ts2 && st.sync && !st.mem_request_active) begin
                    next_st.mem_request_active = 1'b1;
                    next_st.sync               = 1'b0;
                    next_st.phase              = PH_DONE;
                end
            end
            PH_DONE: begin
                if (ts2 && !st.mem_request_active) begin
                    next_st.done_flag   = 1'b1;
                    next_st.seq_started = 1'b0;
                    next_st.go_bit      = 1'b0;
                    next_st.phase       = PH_IDLE;
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase

        // read data one cycle after the strobe
        next_st.rdata = `RST_WORD16;
        if (rd_i) begin
            case (addr_i)
                `OFF_HOST_BUS_ADDRESS:  next_st.rdata = st.host_bus_address;
                `OFF_TABLE_BASE_OFFSET: next_st.rdata = st.table_base_offset;
                `OFF_CONTROL:           next_st.rdata = {10'h000, st.function_code, 2'h0,
                                                         st.done_flag, st.go_bit};
                `OFF_STATUS:            next_st.rdata = {8'h00, st.mem_request_active, st.request_in,
                                                         st.addr_in_tag, st.skip_fetch_flag, st.sync,
                                                         3'(st.phase)};
                `OFF_TRANSFER_DATA:     next_st.rdata = st.transfer_data_reg;
                `OFF_UNIT_ADDR:         next_st.rdata = {8'h00, st.unit_addr_latch};
                `OFF_UNIT_REGS:         next_st.rdata = {st.unit_command_reg, st.unit_status_reg};
                default:                next_st.rdata = `RST_WORD16;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // self reset from zero code behaves like rst_i
    always_ff @(posedge clk_i) begin
        if (rst_i || st.reset_pulse) begin
            st       <= '0;
            st.phase <= PH_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o       = st.rdata;
    assign addr_in_tag_o = st.addr_in_tag;
    assign request_in_o  = st.request_in;
    assign inbound_bus_o = st.inbound_bus;
    assign mem_o         = '{mem_request_active: st.mem_request_active,
                             host_bus_address:   st.host_bus_address};
    assign phase_o       = st.phase;
    assign sync_o        = st.sync;
    assign skip_fetch_o  = st.skip_fetch_flag;

endmodule

/* File: sim/selprep_props.sv */
// port assertions for the selection sequencer
// assumes it is bound to selprep; one clock, synchronous reset
`timescale 1ns/1ps
module selprep_props (
    // clock and register port
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic [3:0]             addr_i,
    input wire logic [15:0]            wdata_i,
    input wire logic                   wr_i,
    input wire logic                   rd_i,
    input wire logic [15:0]            rdata_o,
    // channel side
    input wire selprep_pkg::chan_in_s  chan_i,
    input wire logic                   addr_in_tag_o,
    input wire logic                   request_in_o,
    input wire logic [7:0]             inbound_bus_o,
    // memory and sequencer view
    input wire selprep_pkg::mem_req_s  mem_o,
    input wire logic                   mem_done_i,
    input wire logic [15:0]            mem_data_i,
    input wire selprep_pkg::phase_e    phase_o,
    input wire logic                   sync_o,
    input wire logic                   skip_fetch_o
);
    import selprep_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------
    // cycles since the last completion
    // ------
    logic [3:0] since_done;
    always_ff @(posedge clk_i) begin
        if (rst_i || mem_done_i) begin
            since_done <= 4'h0;
        end else if (since_done != 4'hf) begin
            since_done <= since_done + 4'h1;
        end
    end
    a_idle_request: assert property ($rose(request_in_o) |-> phase_o == PH_IDLE)
        else $error("request-in raised outside idle");
    a_resp_entry: assert property (phase_o == PH_ADDR_RESP && $past(phase_o) != PH_ADDR_RESP |-> $past(phase_o) == PH_IDLE)
        else $error("address response entered from wrong phase");
    a_sync_entry: assert property (phase_o != $past(phase_o) |-> !sync_o)
        else $error("sync set on phase entry");
    a_ptr_request: assert property ($rose(mem_o.mem_request_active) && phase_o == PH_ADDR_RESP |-> sync_o && mem_o.host_bus_address[9] == 1'b0 && mem_o.host_bus_address[0] == 1'b0)
        else $error("pointer request malformed");
    a_resp_exit: assert property ($past(phase_o) == PH_ADDR_RESP && phase_o != PH_ADDR_RESP |-> phase_o inside {PH_STAT_PREP, PH_MARK})
        else $error("address response left to wrong phase");
    a_prep_entry: assert property (phase_o == PH_STAT_PREP && $past(phase_o) != PH_STAT_PREP |-> $past(phase_o) inside {PH_IDLE, PH_ADDR_RESP})
        else $error("preparation entered from wrong phase");
    a_addr_in_rise: assert property ($rose(addr_in_tag_o) |-> phase_o == PH_STAT_PREP && $past(phase_o, 4) == PH_STAT_PREP && !$past(sync_o))
        else $error("address-in raised too early");
    a_addr_in_fall: assert property ($fell(addr_in_tag_o) && phase_o == PH_STAT_PREP |-> $past(chan_i.cmd_out_tag, 3))
        else $error("address-in dropped without command-out");
    a_prep_exit: assert property ($past(phase_o) == PH_STAT_PREP && phase_o != PH_STAT_PREP |-> phase_o inside {PH_STAT_PRES, PH_MARK, PH_INPUT, PH_OUTPUT} && !$past(chan_i.addr_out_tag, 3))
        else $error("preparation left wrongly");
    a_req_until_done: assert property ($fell(mem_o.mem_request_active) |-> since_done <= 4'h8)
        else $error("memory request dropped before completion");
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data outside its cycle");
endmodule

/* File: sim/host_mem_model.sv */
// host memory stand-in answering the sequencer's word reads
// assumes the request is held until done; words preloaded by the bench
`timescale 1ns/1ps
module host_mem_model (
    // clock, reset and latency choice
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  slow_i,
    // request side
    input  wire selprep_pkg::mem_req_s mem_i,
    output logic                       done_o,
    output logic [15:0]                data_o
);
    import selprep_pkg::*;
    logic [15:0] words [logic [15:0]];
    logic [1:0]  st = 2'd0;
    logic [3:0]  wait_cnt = 4'h0;
    logic [15:0] last_a = 16'h0000;
    int          n_req = 0;
    initial done_o = 1'b0;
    initial data_o = 16'h0000;
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i || (st == 2'd0 && !mem_i.mem_request_active)) begin
            st <= 2'd0;
            data_o <= ~data_o;
        end else if (st == 2'd0) begin
            st <= 2'd1;
            n_req <= n_req + 1;
            last_a <= mem_i.host_bus_address;
            wait_cnt <= slow_i ? 4'hb : 4'h1;
        end else if (st == 2'd1 && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (st == 2'd1) begin
            st <= 2'd2;
            done_o <= 1'b1;
            data_o <= words.exists(last_a) ? words[last_a] : ~last_a;
        end else if (!mem_i.mem_request_active) begin
            st <= 2'd0;
        end
    end
endmodule

/* File: sim/test_selprep.sv */
// self-checking bench for the selection sequencer
// assumes selprep, host_mem_model and selprep_props compiled before it
`timescale 1ns/1ps
`include "selprep_regs.svh"
module test_selprep;
    import selprep_pkg::*;
    typedef struct packed { logic [3:0] a; logic [15:0] d; logic [15:0] m; logic [15:0] e; } row_s;
    localparam logic [15:0] OFFS = 16'hfc00;
    localparam logic [7:0]  UNIT = 8'h5a;
    localparam logic [15:0] TBL  = 16'h9c71;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        slow = 1'b0;
    chan_in_s    chan_i = '0;
    logic [15:0] rdata_o, mem_data_i, seen;
    logic        addr_in_tag_o, request_in_o, mem_done_i, sync_o, skip_fetch_o;
    logic [7:0]  inbound_bus_o;
    logic [7:0]  st [2];
    mem_req_s    mem_o;
    phase_e      phase_o;
    int          fails = 0, compares = 0, cycles = 0, base = 0;
    row_s        rows [6] = '{'{`OFF_HOST_BUS_ADDRESS, 16'h1234, 16'hffff, 16'h1234},
        '{`OFF_TABLE_BASE_OFFSET, 16'habcd, 16'hffff, 16'habcd}, '{4'h7, 16'hffff, 16'hffff, 16'h0000},
        '{4'hf, 16'h5a5a, 16'hffff, 16'h0000}, '{`OFF_CONTROL, 16'h0006, 16'h0002, 16'h0002},
        '{`OFF_CONTROL, 16'h0004, 16'h0002, 16'h0000}};
    logic [15:0] bp_ptr [3] = '{16'h4201, 16'h0000, 16'h4200};
    logic [1:0]  bp_fc [3] = '{2'b01, 2'b11, 2'b10};
    phase_e      bp_ph [3] = '{PH_INPUT, PH_STAT_PRES, PH_OUTPUT};

    selprep selprep_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .chan_i(chan_i), .addr_in_tag_o(addr_in_tag_o),
        .request_in_o(request_in_o), .inbound_bus_o(inbound_bus_o), .mem_o(mem_o), .mem_done_i(mem_done_i),
        .mem_data_i(mem_data_i), .phase_o(phase_o), .sync_o(sync_o), .skip_fetch_o(skip_fetch_o));
    host_mem_model host_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_i(mem_o),
        .done_o(mem_done_i), .data_o(mem_data_i));

    always #20 clk_i = ~clk_i;
    // runs take well under a thousand cycles; ceiling of 20000 leaves wide margin
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            tally_and_finish();
        end
    end
    // ------
    // shared tasks
    // ------
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 seen = rdata_o;
    endtask
    task automatic reset_dut(input int n);
        @(posedge clk_i);
        rst_i <= 1'b1;
        chan_i <= '0;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    // one channel selection from go to the end of preparation
    task automatic select(input logic [15:0] ptr, input logic [1:0] fc, input logic chrst, input logic par,
                          input logic [7:0] cmd);
        logic [15:0] pa;
        pa = {OFFS[15:10], 1'b0, UNIT, 1'b0};
        reset_dut(2);
        host_mem_model_inst.words[pa] = ptr;
        host_mem_model_inst.words[{ptr[15:8], cmd}] = TBL;
        base = host_mem_model_inst.n_req;
        wr(`OFF_TABLE_BASE_OFFSET, OFFS);
        wr(`OFF_CONTROL, {10'h000, fc, 4'h1});
        for (int i = 0; i < 50 && request_in_o !== 1'b1; i++) tick();
        chk("request-in", {15'h0, request_in_o}, 16'h0001);
        @(posedge clk_i);
        chan_i <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, par, UNIT};
        for (int i = 0; i < 50 && mem_o.mem_request_active !== 1'b1; i++) tick();
        chk("pointer address", mem_o.host_bus_address, pa);
        @(posedge clk_i);
        chan_i.channel_reset_seen <= chrst;
        for (int i = 0; i < 50 && phase_o === PH_ADDR_RESP; i++) tick();
        chk("phase after pointer", {13'h0, phase_o}, {13'h0, chrst ? PH_MARK : PH_STAT_PREP});
        chk("skip flag", {15'h0, skip_fetch_o}, {15'h0, ptr[7:0] != 8'h00 || ptr[15:8] == 8'h00});
        if (chrst) return;
        chk("echoed address", {8'h00, inbound_bus_o}, {8'h00, UNIT});
        @(posedge clk_i);
        chan_i.addr_out_tag <= 1'b0;
        chan_i.outbound_bus <= cmd;
        for (int i = 0; i < 50 && addr_in_tag_o !== 1'b1; i++) tick();
        chk("address-in", {15'h0, addr_in_tag_o}, 16'h0001);
        @(posedge clk_i);
        chan_i.cmd_out_tag <= 1'b1;
        for (int i = 0; i < 50 && addr_in_tag_o !== 1'b0; i++) tick();
        @(posedge clk_i);
        chan_i.cmd_out_tag <= 1'b0;
        for (int i = 0; i < 100 && phase_o === PH_STAT_PREP; i++) tick();
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        reset_dut(12);
        for (int k = 0; k < 7; k++) begin
            rd(4'(k));
            chk("reset value", seen, `RST_WORD16);
        end
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a);
            chk("register readback", seen & rows[k].m, rows[k].e);
        end
        for (int k = 0; k < 2; k++) begin
            select(16'h4200, 2'b10, 1'b0, 1'b1, 8'h03 - 8'(k));
            chk("phase after fetch", {13'h0, phase_o}, {13'h0, PH_STAT_PRES});
            chk("table address", host_mem_model_inst.last_a, {8'h42, 8'h03 - 8'(k)});
            rd(`OFF_UNIT_REGS);
            chk("latched command", {8'h00, seen[15:8]}, {8'h00, 8'h03 - 8'(k)});
            st[k] = seen[7:0];
        end
        chk("status bytes", {15'h0, {st[0], st[1]} inside {TBL, {TBL[7:0], TBL[15:8]}}}, 16'h0001);
        // done set only as a diagnostic
        wr(`OFF_CONTROL, 16'h0027);
        rd(`OFF_CONTROL);
        chk("done outside idle", seen & 16'h0002, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            select(bp_ptr[k], bp_fc[k], 1'b0, k != 2, 8'h03);
            chk("bypass requests", 16'(host_mem_model_inst.n_req - base), 16'h0001);
            chk("bypass phase", {13'h0, phase_o}, {13'h0, bp_ph[k]});
        end
        slow = 1'b1;
        select(16'h4200, 2'b10, 1'b1, 1'b1, 8'h03);
        for (int i = 0; i < 300 && host_mem_model_inst.n_req - base < 3; i++) tick();
        chk("mark writes", 16'(host_mem_model_inst.n_req - base), 16'h0003);
        slow = 1'b0;
        reset_dut(2);
        wr(`OFF_HOST_BUS_ADDRESS, 16'h1234);
        wr(`OFF_CONTROL, 16'h0001);
        repeat (8) @(posedge clk_i);
        rd(`OFF_HOST_BUS_ADDRESS);
        chk("self reset", seen, `RST_WORD16);
        tally_and_finish();
    end
endmodule

bind selprep selprep_props selprep_props_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .chan_i(chan_i), .addr_in_tag_o(addr_in_tag_o),
    .request_in_o(request_in_o), .inbound_bus_o(inbound_bus_o), .mem_o(mem_o), .mem_done_i(mem_done_i),
    .mem_data_i(mem_data_i), .phase_o(phase_o), .sync_o(sync_o), .skip_fetch_o(skip_fetch_o));
